// ===== rtl/motion_sensor_serial_sequencer.sv
// serial port, burst readout, frame capture and power modes of the motion sensor
`timescale 1ns/100ps
`default_nettype none
module motion_sensor_serial_sequencer #(
  parameter int SELFTEST_CYCLES = sensor_pkg::SELFTEST_CYCLES
) (
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // serial link
  input  wire logic        sclk,
  input  wire logic        select_low,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  // motion measurements from the optical core
  input  wire logic        delta_valid,
  input  wire logic [11:0] delta_x,
  input  wire logic [11:0] delta_y,
  input  wire logic [7:0]  surface_quality,
  input  wire logic [15:0] exposure,
  input  wire logic [7:0]  brightest_pixel,
  input  wire logic [7:0]  mean_pixel,
  input  wire logic [7:0]  darkest_pixel,
  // pixel stream from the optical core
  input  wire logic        frame_start,
  input  wire logic        pixel_valid,
  input  wire logic [7:0]  pixel_data,
  // status pins
  output logic             motion_low,
  output logic             laser_enable_out,
  output logic             rest_mode,
  output logic             port_clock_on,
  output logic             tracking_halted
);

  // ==========================================================
  // declarations
  sensor_pkg::link_state_t state;
  logic [2:0]  bit_cnt;
  logic [6:0]  rx_shift;
  logic        cmd_write;
  logic [6:0]  cmd_addr;
  logic [7:0]  wr_data;
  logic [8:0]  byte_idx;
  logic        wr_toggle;
  logic        rd_toggle;
  logic        link_reset;
  logic        shut_link;
  logic        grab_link;
  logic [7:0]  tx_byte;
  logic        addr_done;
  logic        data_done;
  logic        wr_evt;
  logic        rd_evt;
  logic        sel_high_s;
  logic        burst_s;
  logic        burst_s_last;
  logic [7:0]  rd_value;
  logic [7:0]  perf;
  logic [7:0]  cfg_a;
  logic [7:0]  cfg_b;
  logic [7:0]  cfg_c;
  logic [7:0]  observation;
  logic [7:0]  testclk;
  logic        shutdown;
  logic        grab_armed;
  logic        capturing;
  logic        frame_ready;
  logic [7:0]  cap_idx;
  logic [11:0] acc_x;
  logic [11:0] acc_y;
  logic        st_run;
  logic [31:0] st_count;
  logic [7:0]  hold      [sensor_pkg::REPORT_BYTES];
  logic [7:0]  next_hold [sensor_pkg::REPORT_BYTES];
  logic [7:0]  pixel_mem [sensor_pkg::FRAME_PIXELS];

  // ==========================================================
  // crossings: reset and levels into the link, events out of it
  sync2 #(.WIDTH(3)) u_link_sync (
    .clk      (sclk),
    .async_in ({reset, shutdown, frame_ready}),
    .sync_out ({link_reset, shut_link, grab_link})
  );

  sync2 #(.WIDTH(2)) u_sys_sync (
    .clk      (clk),
    .async_in ({select_low, state == sensor_pkg::L_BURST}),
    .sync_out ({sel_high_s, burst_s})
  );

  toggle_pulse u_wr_evt (
    .clk       (clk),
    .reset     (reset),
    .toggle_in (wr_toggle),
    .pulse     (wr_evt)
  );

  toggle_pulse u_rd_evt (
    .clk       (clk),
    .reset     (reset),
    .toggle_in (rd_toggle),
    .pulse     (rd_evt)
  );

  // ==========================================================
  // link side: bit engine, cleared whenever select is high
  assign addr_done = (state == sensor_pkg::L_ADDR) && (bit_cnt == 3'h7);
  assign data_done = (state == sensor_pkg::L_DATA) && (bit_cnt == 3'h7);

  // sample on rising edges only while selected
  always_ff @(posedge sclk or posedge select_low)
  begin
    if (select_low)
    begin
      state     <= sensor_pkg::L_ADDR;
      bit_cnt   <= 3'h0;
      rx_shift  <= 7'h00;
      cmd_write <= 1'b0;
      cmd_addr  <= 7'h00;
      wr_data   <= 8'h00;
      byte_idx  <= 9'h000;
    end
    else
    begin
      rx_shift <= {rx_shift[5:0], sdio_in};
      bit_cnt  <= bit_cnt + 3'h1;
      if (addr_done)
      begin
        cmd_write <= rx_shift[6];
        cmd_addr  <= {rx_shift[5:0], sdio_in};
        // burst keeps the port busy until select rises
        if (!rx_shift[6] && {rx_shift[5:0], sdio_in} == sensor_pkg::ADDR_BURST
            && !shut_link)
          state <= sensor_pkg::L_BURST;
        else
          state <= sensor_pkg::L_DATA;
      end
      else if (data_done)
      begin
        state <= sensor_pkg::L_ADDR;
        if (cmd_write)
          wr_data <= {rx_shift, sdio_in};
      end
      else if (state == sensor_pkg::L_BURST && bit_cnt == 3'h7)
        byte_idx <= byte_idx + 9'h001;
    end
  end

  // event toggles survive select so no edge is lost
  always_ff @(posedge sclk)
  begin
    if (link_reset)
    begin
      wr_toggle <= 1'b0;
      rd_toggle <= 1'b0;
    end
    else if (!select_low)
    begin
      if (data_done && cmd_write)
        wr_toggle <= ~wr_toggle;
      if (addr_done && !rx_shift[6])
        rd_toggle <= ~rd_toggle;
    end
  end

  // ==========================================================
  // transmit byte: single read, report burst or pixel burst
  always_comb
  begin
    tx_byte = sensor_pkg::ZERO_BYTE;
    if (state == sensor_pkg::L_BURST)
    begin
      if (grab_link)
      begin
        if (byte_idx < 9'(sensor_pkg::FRAME_PIXELS))
          tx_byte = pixel_mem[byte_idx[7:0]];
      end
      else if (byte_idx < 9'(sensor_pkg::REPORT_BYTES))
        tx_byte = hold[byte_idx[3:0] + sensor_pkg::BURST_START];
    end
    else
      tx_byte = rd_value;
  end

  // drive on falling edges; data words are stable over the host pause
  always_ff @(negedge sclk or posedge select_low)
  begin
    if (select_low)
    begin
      sdio_oe  <= 1'b0;
      sdio_out <= 1'b0;
    end
    else
    begin
      sdio_oe  <= !shut_link && (state == sensor_pkg::L_BURST ||
                  (state == sensor_pkg::L_DATA && !cmd_write));
      sdio_out <= tx_byte[3'h7 - bit_cnt];
    end
  end

  // ==========================================================
  // system side: register writes and power modes
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      perf          <= sensor_pkg::PERF_RESET;
      cfg_a         <= sensor_pkg::CFG_A_RESET;
      cfg_b         <= sensor_pkg::CFG_B_RESET;
      cfg_c         <= sensor_pkg::CFG_C_RESET;
      testclk       <= sensor_pkg::ZERO_BYTE;
      shutdown      <= 1'b0;
      port_clock_on <= 1'b0;
    end
    else if (wr_evt && shutdown)
    begin
      // only the wake command is honoured; settings are kept
      if (cmd_addr == sensor_pkg::ADDR_WAKE && wr_data == sensor_pkg::WAKE_VAL)
        shutdown <= 1'b0;
    end
    else if (wr_evt)
    begin
      if (cmd_addr == sensor_pkg::ADDR_PERF)
        perf <= wr_data;
      else if (cmd_addr == sensor_pkg::ADDR_CFG_A)
        cfg_a <= wr_data;
      else if (cmd_addr == sensor_pkg::ADDR_CFG_B)
        cfg_b <= wr_data;
      else if (cmd_addr == sensor_pkg::ADDR_CFG_C)
        cfg_c <= wr_data;
      else if (cmd_addr == sensor_pkg::ADDR_TESTCLK)
        testclk <= wr_data;
      else if (cmd_addr == sensor_pkg::ADDR_SLEEP && wr_data == sensor_pkg::SLEEP_VAL)
        shutdown <= 1'b1;
      else if (cmd_addr == sensor_pkg::ADDR_CLKREQ && wr_data == sensor_pkg::CLK_ON_VAL)
        port_clock_on <= 1'b1;
      else if (cmd_addr == sensor_pkg::ADDR_CLKREQ && wr_data == sensor_pkg::CLK_OFF_VAL)
        port_clock_on <= 1'b0;
    end
  end

  // status pins straight from flops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rest_mode        <= 1'b0;
      laser_enable_out <= 1'b0;
      motion_low       <= 1'b1;
    end
    else
    begin
      rest_mode        <= !perf[sensor_pkg::REST_OFF_BIT] && !shutdown;
      laser_enable_out <= !shutdown && !tracking_halted;
      motion_low       <= !(acc_x != 12'h000 || acc_y != 12'h000);
    end
  end

  // ==========================================================
  // self-test: load the written byte, then bits 3..0 come up after the test time
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      observation <= sensor_pkg::ZERO_BYTE;
      st_run      <= 1'b0;
      st_count    <= 32'h0000_0000;
    end
    else if (st_run && st_count == 32'(SELFTEST_CYCLES - 1))
    begin
      st_run           <= 1'b0;
      observation[3:0] <= sensor_pkg::SELFTEST_OK;
    end
    else if (wr_evt && !shutdown && cmd_addr == sensor_pkg::ADDR_OBS)
    begin
      observation <= wr_data;
      st_run      <= 1'b1;
      st_count    <= 32'h0000_0000;
    end
    else if (st_run)
      st_count <= st_count + 32'h0000_0001;
  end

  // ==========================================================
  // motion accumulation; write to the motion register drops residue
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      acc_x <= 12'h000;
      acc_y <= 12'h000;
    end
    else if (wr_evt && !shutdown && cmd_addr == sensor_pkg::ADDR_MOTION)
    begin
      acc_x <= 12'h000;
      acc_y <= 12'h000;
    end
    else if (delta_valid && !shutdown && !tracking_halted)
    begin
      acc_x <= acc_x + delta_x;
      acc_y <= acc_y + delta_y;
    end
  end

  // report snapshot in burst order
  always_comb
  begin
    next_hold[0] = {acc_x != 12'h000 || acc_y != 12'h000, 7'h00};
    next_hold[1] = acc_x[7:0];
    next_hold[2] = acc_y[7:0];
    next_hold[3] = {acc_x[11:8], acc_y[11:8]};
    next_hold[4] = surface_quality;
    next_hold[5] = exposure[15:8];
    next_hold[6] = exposure[7:0];
    next_hold[7] = brightest_pixel;
    next_hold[8] = mean_pixel;
    next_hold[9] = darkest_pixel;
  end

  // refreshed in every mode, rest included; frozen while a burst streams
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < sensor_pkg::REPORT_BYTES; i++)
        hold[i] <= sensor_pkg::ZERO_BYTE;
    end
    else if (!burst_s)
    begin
      for (int i = 0; i < sensor_pkg::REPORT_BYTES; i++)
        hold[i] <= next_hold[i];
    end
  end

  // ==========================================================
  // single reads: value ready before the host resumes clocking
  always_ff @(posedge clk)
  begin
    if (reset)
      rd_value <= sensor_pkg::ZERO_BYTE;
    else if (rd_evt)
    begin
      if (cmd_addr >= sensor_pkg::ADDR_MOTION && cmd_addr <= sensor_pkg::ADDR_LAST_RO)
        rd_value <= hold[4'(cmd_addr - sensor_pkg::ADDR_MOTION)];
      else if (cmd_addr == sensor_pkg::ADDR_PERF)
        rd_value <= perf;
      else if (cmd_addr == sensor_pkg::ADDR_CFG_A)
        rd_value <= cfg_a;
      else if (cmd_addr == sensor_pkg::ADDR_CFG_B)
        rd_value <= cfg_b;
      else if (cmd_addr == sensor_pkg::ADDR_CFG_C)
        rd_value <= cfg_c;
      else if (cmd_addr == sensor_pkg::ADDR_OBS)
        rd_value <= observation;
      else if (cmd_addr == sensor_pkg::ADDR_TESTCLK)
        rd_value <= testclk;
      else
        rd_value <= sensor_pkg::ZERO_BYTE;
    end
  end

  // ==========================================================
  // frame capture: arm, store next whole frame, halt after readout
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      grab_armed      <= 1'b0;
      capturing       <= 1'b0;
      frame_ready     <= 1'b0;
      cap_idx         <= 8'h00;
      tracking_halted <= 1'b0;
      burst_s_last    <= 1'b0;
    end
    else
    begin
      burst_s_last <= burst_s;
      if (wr_evt && !shutdown && cmd_addr == sensor_pkg::ADDR_GRAB
          && wr_data == sensor_pkg::GRAB_VAL)
        grab_armed <= 1'b1;
      else if (grab_armed && frame_start)
      begin
        grab_armed <= 1'b0;
        capturing  <= 1'b1;
        cap_idx    <= 8'h00;
      end
      else if (capturing && pixel_valid)
      begin
        cap_idx <= cap_idx + 8'h01;
        if (cap_idx == 8'(sensor_pkg::FRAME_PIXELS - 1))
        begin
          capturing   <= 1'b0;
          frame_ready <= 1'b1;
        end
      end
      if (frame_ready && burst_s_last && !burst_s)
        tracking_halted <= 1'b1;
    end
  end

  // pixel store written only while capturing
  always_ff @(posedge clk)
  begin
    if (capturing && pixel_valid)
      pixel_mem[cap_idx] <= pixel_data;
  end

  // ==========================================================
  // checks
  a_sleep_entry: assert property (@(posedge clk) disable iff (reset)
    wr_evt && !shutdown && cmd_addr == sensor_pkg::ADDR_SLEEP
      && wr_data == sensor_pkg::SLEEP_VAL |=> shutdown ##2 !laser_enable_out)
    else $error("shutdown command not obeyed");

  a_wake_only: assert property (@(posedge clk) disable iff (reset)
    shutdown && wr_evt && !(cmd_addr == sensor_pkg::ADDR_WAKE
      && wr_data == sensor_pkg::WAKE_VAL) |=> shutdown && $stable(perf) && $stable(cfg_c))
    else $error("non-wake write acted in shutdown");

  a_wake_keeps: assert property (@(posedge clk) disable iff (reset)
    shutdown && wr_evt && cmd_addr == sensor_pkg::ADDR_WAKE
      && wr_data == sensor_pkg::WAKE_VAL |=> !shutdown && $stable(cfg_a))
    else $error("wake command failed");

  a_selftest_bits: assert property (@(posedge clk) disable iff (reset)
    st_run && st_count == 32'(SELFTEST_CYCLES - 1) && !wr_evt |=> !st_run
      && observation[3:0] == sensor_pkg::SELFTEST_OK)
    else $error("self-test bits not set");

  a_hold_frozen: assert property (@(posedge clk) disable iff (reset)
    burst_s ##1 burst_s |-> $stable(hold[0]) && $stable(hold[9]))
    else $error("report changed during burst");

  a_halt_grab: assert property (@(posedge clk) disable iff (reset)
    frame_ready && $fell(burst_s) |=> tracking_halted ##1 !laser_enable_out)
    else $error("tracking not halted after image");

  a_rest_select: assert property (@(posedge clk) disable iff (reset)
    wr_evt && !shutdown && cmd_addr == sensor_pkg::ADDR_PERF ##1 !wr_evt
      |=> rest_mode == !perf[sensor_pkg::REST_OFF_BIT])
    else $error("rest mode does not follow register");

  a_idle_quiet: assert property (@(posedge clk) disable iff (reset)
    sel_high_s [*2] |-> !sdio_oe && !burst_s)
    else $error("drive while deselected");

  a_burst_entry: assert property (@(posedge sclk) disable iff (select_low)
    addr_done && !rx_shift[6] && {rx_shift[5:0], sdio_in} == sensor_pkg::ADDR_BURST
      && !shut_link |=> state == sensor_pkg::L_BURST && byte_idx == 9'h000)
    else $error("burst not entered");

  a_burst_order: assert property (@(posedge sclk) disable iff (select_low)
    state == sensor_pkg::L_BURST && !grab_link && byte_idx == 9'h003
      |-> tx_byte == hold[3])
    else $error("burst byte out of order");

endmodule
`default_nettype wire

// ===== rtl/sensor_pkg.sv
// constants, register offsets and types of the motion sensor serial sequencer
package sensor_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ         = 125;
  localparam int SELFTEST_MS     = 10;
  localparam int SELFTEST_CYCLES = SELFTEST_MS * CLK_MHZ * 1000;

  // ==========================================================
  // register offsets (seven-bit addresses)
  localparam logic [6:0] ADDR_MOTION  = 7'h02;
  localparam logic [6:0] ADDR_LAST_RO = 7'h0B;
  localparam logic [6:0] ADDR_PERF    = 7'h11;
  localparam logic [6:0] ADDR_BURST   = 7'h12;
  localparam logic [6:0] ADDR_CFG_A   = 7'h1B;
  localparam logic [6:0] ADDR_CFG_B   = 7'h1C;
  localparam logic [6:0] ADDR_CFG_C   = 7'h1D;
  localparam logic [6:0] ADDR_OBS     = 7'h2D;
  localparam logic [6:0] ADDR_TESTCLK = 7'h32;
  localparam logic [6:0] ADDR_GRAB    = 7'h36;
  localparam logic [6:0] ADDR_WAKE    = 7'h3A;
  localparam logic [6:0] ADDR_SLEEP   = 7'h3B;
  localparam logic [6:0] ADDR_CLKREQ  = 7'h41;

  // ==========================================================
  // command values, field positions, reset values
  localparam logic [7:0] GRAB_VAL    = 8'h80;
  localparam logic [7:0] SLEEP_VAL   = 8'hE7;
  localparam logic [7:0] WAKE_VAL    = 8'h96;
  localparam logic [7:0] CLK_ON_VAL  = 8'hBA;
  localparam logic [7:0] CLK_OFF_VAL = 8'hB5;
  localparam logic [7:0] PERF_RESET  = 8'h01;
  localparam logic [7:0] CFG_A_RESET = 8'h04;
  localparam logic [7:0] CFG_B_RESET = 8'h04;
  localparam logic [7:0] CFG_C_RESET = 8'h1F;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam logic [3:0] SELFTEST_OK = 4'hF;
  localparam int         WRITE_BIT   = 7;
  localparam int         MOTION_BIT  = 7;
  localparam int         REST_OFF_BIT = 7;
  localparam logic [3:0] BURST_START = 4'h0;

  // ==========================================================
  // burst sizes
  localparam int REPORT_BYTES = 10;
  localparam int FRAME_PIXELS = 256;

  typedef enum logic [1:0] {
    L_ADDR  = 2'b00,
    L_DATA  = 2'b01,
    L_BURST = 2'b11
  } link_state_t;

endpackage

// ===== rtl/sync2.sv
// two-flop level synchroniser, parameterised width
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             clk,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // ==========================================================
  // first stage is read only by the second
  always_ff @(posedge clk)
  begin
    meta     <= async_in;
    sync_out <= meta;
  end

endmodule
`default_nettype wire

// ===== rtl/toggle_pulse.sv
// toggle-to-pulse event crossing into the receiving clock domain
`timescale 1ns/100ps
`default_nettype none
module toggle_pulse (
  // clock and reset of receiving side
  input  wire logic clk,
  input  wire logic reset,
  // toggle from far domain, pulse here
  input  wire logic toggle_in,
  output logic      pulse
);

  logic toggle_s;
  logic toggle_last;

  sync2 #(.WIDTH(1)) u_sync (
    .clk      (clk),
    .async_in (toggle_in),
    .sync_out (toggle_s)
  );

  // ==========================================================
  // one pulse per change of the synchronised toggle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      toggle_last <= 1'b0;
      pulse       <= 1'b0;
    end
    else
    begin
      toggle_last <= toggle_s;
      pulse       <= toggle_s ^ toggle_last;
    end
  end

endmodule
`default_nettype wire

// ===== tb/host_model.sv
// host-side serial master model for the sensor link
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // serial link
  output logic      sclk,
  output logic      select_low,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe
);
  logic       host_oe;
  logic       host_d;
  logic       last;
  logic [7:0] rx;
  event       got;

  // ==========================================================
  // wire level: undriven line shows the inverse of its last bit
  always_comb
    sdio_in = sdio_oe ? sdio_out : (host_oe ? host_d : ~last);
  always @(posedge sclk)
    last <= sdio_in;

  // clock stands high outside frames
  initial
  begin
    sclk = 1'b1;
    select_low = 1'b1;
    host_oe = 1'b0;
    host_d = 1'b0;
    last = 1'b0;
  end

  // one byte, msb first, changed on falling edges
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      host_oe = 1'b1;
      host_d = b[i];
      #6;
      sclk = 1'b1;
      #6;
    end
  endtask

  // clock pulses with select high; the port ignores them, but they
  // let the link flops take the system reset
  task automatic idle_clk(input int n);
    repeat (n)
    begin
      #3 sclk = 1'b0;
      #6 sclk = 1'b1;
      #3;
    end
  endtask

  // write: address byte with write bit set, then data
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    select_low = 1'b0;
    send({1'b1, a});
    send(d);
    host_oe = 1'b0;
    #80;
    select_low = 1'b1;
    #40;
  endtask

  // read of n bytes; at the burst address n may stop short
  task automatic rd(input logic [6:0] a, input int n);
    select_low = 1'b0;
    send({1'b0, a});
    host_oe = 1'b0;
    #100;
    repeat (n)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        sclk = 1'b0;
        #6;
        sclk = 1'b1;
        rx[i] = sdio_in;
        #6;
      end
      -> got;
    end
    #260;
    select_low = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the motion sensor serial sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("MISMATCH t=%0t got %h want %h", $time, a, b); \
    end \
  end
module tb_top;
  logic        clk, reset, sclk, select_low, sdio_in, sdio_out, sdio_oe;
  logic        delta_valid, frame_start, pixel_valid;
  logic [11:0] delta_x, delta_y;
  logic [7:0]  surface_quality, brightest_pixel, mean_pixel, darkest_pixel, pixel_data;
  logic [15:0] exposure;
  logic        motion_low, laser_enable_out, rest_mode, port_clock_on, tracking_halted;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_byte;
  int          err_total, n_compared, cycles;
  logic [31:0] seed;

  // ==========================================================
  // design, host and clock
  motion_sensor_serial_sequencer #(.SELFTEST_CYCLES(20)) u_dut (
    .clk, .reset, .sclk, .select_low, .sdio_in, .sdio_out, .sdio_oe,
    .delta_valid, .delta_x, .delta_y, .surface_quality, .exposure,
    .brightest_pixel, .mean_pixel, .darkest_pixel, .frame_start, .pixel_valid,
    .pixel_data, .motion_low, .laser_enable_out, .rest_mode, .port_clock_on,
    .tracking_halted
  );
  host_model u_host (.sclk, .select_low, .sdio_in, .sdio_out, .sdio_oe);
  always #4 clk = ~clk;

  // verdict and end of run
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // each byte the host reads is held against the oldest note
  always @(u_host.got)
  begin
    exp_byte = exp_q.pop_front();
    `CHK(u_host.rx, exp_byte)
  end

  // hang guard, far above the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run;
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    seed = 32'h0D3A;
    {delta_valid, frame_start, pixel_valid, pixel_data} = 11'h000;
    {delta_x, delta_y} = 24'($random(seed));
    {surface_quality, exposure, brightest_pixel} = 32'($random(seed));
    {mean_pixel, darkest_pixel} = 16'($random(seed));
    // link toggles clear only from sclk, so it runs while reset is held
    u_host.idle_clk(5);
    @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    `CHK({rest_mode, laser_enable_out, motion_low, port_clock_on}, 4'hE)
    // self-test, with the long wait shortened by parameter
    u_host.wr(sensor_pkg::ADDR_OBS, sensor_pkg::ZERO_BYTE);
    repeat (40) @(negedge clk);
    exp_q.push_back(8'h0F);
    u_host.rd(sensor_pkg::ADDR_OBS, 1);
    // power-up reads of the first four motion report bytes, once each; no motion yet
    for (int k = 0; k < 4; k++)
    begin
      exp_q.push_back(sensor_pkg::ZERO_BYTE);
      u_host.rd(sensor_pkg::ADDR_MOTION + 7'(k), 1);
    end
    u_host.wr(sensor_pkg::ADDR_CLKREQ, sensor_pkg::CLK_ON_VAL);
    `CHK(port_clock_on, 1'b1)
    u_host.wr(sensor_pkg::ADDR_CLKREQ, sensor_pkg::CLK_OFF_VAL);
    `CHK(port_clock_on, 1'b0)
    u_host.wr(sensor_pkg::ADDR_PERF, 8'h80);
    `CHK(rest_mode, 1'b0)
    u_host.wr(sensor_pkg::ADDR_PERF, 8'h0D);
    `CHK(rest_mode, 1'b1)
    u_host.wr(sensor_pkg::ADDR_CFG_A, 8'h04);
    u_host.wr(sensor_pkg::ADDR_CFG_B, 8'h04);
    u_host.wr(sensor_pkg::ADDR_CFG_C, 8'h0F);
    // one motion report, read whole and then in part
    @(negedge clk);
    delta_x[0] = 1'b1;
    delta_valid = 1'b1;
    @(negedge clk);
    delta_valid = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(motion_low, 1'b0)
    exp_q = '{8'h80, delta_x[7:0], delta_y[7:0], {delta_x[11:8], delta_y[11:8]},
              surface_quality, exposure[15:8], exposure[7:0], brightest_pixel,
              mean_pixel, darkest_pixel, 8'h00};
    u_host.rd(sensor_pkg::ADDR_BURST, 11);
    exp_q = '{8'h80, delta_x[7:0], delta_y[7:0]};
    u_host.rd(sensor_pkg::ADDR_BURST, 3);
    u_host.wr(sensor_pkg::ADDR_MOTION, 8'h00);
    `CHK(motion_low, 1'b1)
    // shutdown refuses other writes, wake keeps the settings
    u_host.wr(sensor_pkg::ADDR_SLEEP, sensor_pkg::SLEEP_VAL);
    `CHK({laser_enable_out, rest_mode}, 2'b00)
    // deliberate stray write in shutdown, to see it refused
    u_host.wr(sensor_pkg::ADDR_PERF, 8'h80);
    u_host.wr(sensor_pkg::ADDR_WAKE, sensor_pkg::WAKE_VAL);
    `CHK({laser_enable_out, rest_mode}, 2'b11)
    exp_q.push_back(8'h0F);
    u_host.rd(sensor_pkg::ADDR_CFG_C, 1);
    // frame capture; the frame lands at once, so no long wait
    u_host.wr(sensor_pkg::ADDR_PERF, 8'hF1);
    u_host.wr(sensor_pkg::ADDR_CLKREQ, sensor_pkg::CLK_ON_VAL);
    u_host.wr(sensor_pkg::ADDR_TESTCLK, 8'h10);
    u_host.wr(sensor_pkg::ADDR_GRAB, sensor_pkg::GRAB_VAL);
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    for (int i = 0; i < sensor_pkg::FRAME_PIXELS; i++)
    begin
      pixel_valid = 1'b1;
      pixel_data = 8'($random(seed));
      exp_q.push_back(pixel_data);
      @(negedge clk);
    end
    pixel_valid = 1'b0;
    exp_q.push_back(8'h00);
    repeat (8) @(negedge clk);
    u_host.rd(sensor_pkg::ADDR_BURST, sensor_pkg::FRAME_PIXELS + 1);
    repeat (8) @(negedge clk);
    `CHK({tracking_halted, laser_enable_out}, 2'b10)
    `CHK(exp_q.size(), 0)
    complete_run;
  end
endmodule
`default_nettype wire
